// >>> bench/sdis_dram_model.sv
/*
 * Behavioural DRAM seen from its command pins: counts commands and timing faults.
 * Assumes the pins come straight from the sequencer and that clk_en_i gates its clock.
 */
`include "sdis_regs.svh"

module sdis_dram_model #(
	parameter int STABLE_CYC = 20
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// Command pins.
	input wire sdis_pkg::sdis_pins_t pins_i,
	// Observed state.
	output int viol_o,
	output int refs_o,
	output int mrs_o,
	output logic [11:0] mode_o,
	output logic sr_o,
	output logic refs_first_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int cyc, gap, need, dwell;
	logic cke_q, pre_q, done_q;
	logic [3:0] cmd;
	assign cmd = {pins_i.cs_n, pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
	////////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			{cyc, gap, need, dwell, viol_o, refs_o, mrs_o} = '0;
			{cke_q, pre_q, done_q, sr_o, refs_first_o, mode_o} = '0;
		end
		else
		begin
			// Time passes in self refresh even while the clock is gated.
			if (sr_o)
				dwell++;
		end
		if (!rst_i && clk_en_i)
		begin
			cyc++;
			gap++;
			if (!done_q && (pins_i.dqm !== 2'h3)) viol_o++;
			if (!done_q && !pins_i.cke && !sr_o && cmd !== 4'h7) viol_o++;
			if (!cke_q && pins_i.cke && !sr_o && cyc < STABLE_CYC) viol_o++;
			if (sr_o)
			begin
				if (pins_i.cke)
				begin
					if (dwell < `SDIS_ROWACT_CYC || pins_i.cs_n !== 1'b1) viol_o++;
					sr_o = 1'b0;
					gap = 0;
					need = `SDIS_XSR_CYC;
				end
			end
			else if (cke_q && !pins_i.cke && cmd === 4'h1)
			begin
				sr_o = 1'b1;
				dwell = 0;
			end
			else if (cke_q && pins_i.cke && cmd !== 4'h7 && cmd !== 4'hF)
			begin
				if (gap < need) viol_o++;
				if (cmd !== 4'h2 && !pre_q) viol_o++;
				gap = 0;
				case (cmd)
					4'h2: begin pre_q = pins_i.addr[10]; need = `SDIS_PRE_CYC; end
					4'h0: begin mrs_o++; mode_o = pins_i.addr; need = 2; end
					4'h1: begin refs_o++; refs_first_o |= (mrs_o == 0); need = 6; end
					default: viol_o++;
				endcase
			end
			if (mrs_o > 0 && refs_o >= 2) done_q = 1'b1;
			cke_q = pins_i.cke;
		end
	end
endmodule

// >>> bench/tb_top.sv
/*
 * Self-checking bench for the power-up and self refresh sequencer.
 * Assumes the DRAM model file and the design files are compiled first.
 */
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
`define WAITFOR(c, lim) begin n = 0; while (!(c) && n < lim) begin @(negedge ref_clk_i); \
	n++; end if (n >= lim) begin n_mismatch++; $display("CHECK FAILED t=%0t wait", $time); end end

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int STABLE = 20;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] mode_word = 12'h000;
	logic ref_after_mode = 1'b1, burst = 1'b0, sr_enter = 1'b0, sr_exit = 1'b0;
	logic ready, in_sr, clk_en;
	sdis_pkg::sdis_pins_t pins;
	int viol, refs, mrs, n, r0, n_mismatch = 0, cmp_count = 0;
	logic [11:0] mode;
	logic m_sr, refs_first;
	sdis_seq #(.STABLE_CYC(STABLE), .BURST_REFS(4)) i_sdis_seq (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .mode_word_i(mode_word), .ref_after_mode_i(ref_after_mode),
		.burst_refresh_i(burst), .sr_enter_i(sr_enter), .sr_exit_i(sr_exit),
		.ready_o(ready), .in_self_refresh_o(in_sr), .pins_o(pins), .clk_en_o(clk_en));
	sdis_dram_model #(.STABLE_CYC(STABLE)) i_sdis_dram_model (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .clk_en_i(clk_en), .pins_i(pins), .viol_o(viol), .refs_o(refs),
		.mrs_o(mrs), .mode_o(mode), .sr_o(m_sr), .refs_first_o(refs_first));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Power-up with either refresh order, timing the clock enable rise.
	task automatic do_reset(input logic order, input logic [11:0] word);
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		ref_after_mode = order;
		mode_word = word;
		repeat (20) @(negedge ref_clk_i);
		rst_i = 1'b0;
		`WAITFOR(pins.cke === 1'b1, 1000)
		`CHK(n >= STABLE, 1'b1)
		`WAITFOR(ready === 1'b1, 200)
		`CHK(viol, 0)
		`CHK(mrs, 1)
		`CHK(mode, word)
		`CHK(refs, 2)
		`CHK(refs_first, ~order)
	endtask
	// Entry, held exit request, dwell and exit recovery.
	task automatic do_sr(input logic b);
		@(negedge ref_clk_i);
		burst = b;
		sr_enter = 1'b1;
		r0 = refs;
		`WAITFOR(in_sr === 1'b1, 200)
		@(negedge ref_clk_i);
		sr_enter = 1'b0;
		sr_exit = 1'b1;
		`CHK(m_sr, 1'b1)
		repeat (2) @(negedge ref_clk_i);
		`CHK({clk_en, pins.cke}, 2'h0)
		`WAITFOR(in_sr === 1'b0, 200)
		`WAITFOR(ready === 1'b1, 200)
		@(negedge ref_clk_i);
		sr_exit = 1'b0;
		`CHK(m_sr, 1'b0)
		`CHK(viol, 0)
		`CHK(refs - r0, b ? 8 : 0)
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		do_reset(1'b1, 12'h023);
		do_sr(1'b0);
		do_sr(1'b1);
		do_reset(1'b0, 12'h032);
		do_sr(1'b1);
		wrap_up();
	end
	initial
	begin
		repeat (5000) @(posedge ref_clk_i);
		n_mismatch++;
		wrap_up();
	end
endmodule

// >>> hdl/sdis_seq.sv
/*
 * Controller-side sequencer that powers up a synchronous DRAM and moves it
 * into and out of self refresh, driving the command pins directly.
 * Assumes the DRAM clock is this module's clock and that the DRAM clock
 * output may be gated by clk_en_o; no other traffic is issued meanwhile.
 */
`include "sdis_regs.svh"

module sdis_seq #(
	parameter int STABLE_CYC = `SDIS_STABLE_CYC,
	parameter int BURST_REFS = `SDIS_BURST_REFS
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// User control.
	input wire logic [11:0] mode_word_i,
	input wire logic ref_after_mode_i,
	input wire logic burst_refresh_i,
	input wire logic sr_enter_i,
	input wire logic sr_exit_i,
	output logic ready_o,
	output logic in_self_refresh_o,
	// DRAM pins.
	output sdis_pkg::sdis_pins_t pins_o,
	output logic clk_en_o
);

	typedef enum logic [3:0] {
		ST_POWER, ST_PRE, ST_MODE, ST_REF, ST_IDLE, ST_SR_BREF, ST_SR_ENTER,
		ST_SR_HOLD, ST_SR_CLK, ST_SR_EXIT, ST_SR_AREF
	} sdis_state_t;

	sdis_state_t state_q;
	sdis_pkg::sdis_pins_t pins_q;
	logic clk_en_q, ready_q, sr_q, mode_done_q, refs_done_q;
	logic [12:0] ref_cnt_q;
	logic wait_load, wait_done;
	logic [`SDIS_CNT_W-1:0] wait_cnt, pwr_cnt_q;

	function automatic sdis_pkg::sdis_pins_t mk_cmd(input logic cke, input logic [3:0] cmd,
		input logic [11:0] addr);
		sdis_pkg::sdis_pins_t p;
		p.cke = cke;
		{p.cs_n, p.ras_n, p.cas_n, p.we_n} = cmd;
		p.dqm = 2'h3;
		p.ba = 2'h0;
		p.addr = addr;
		return p;
	endfunction

	sdis_wait u_wait (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.load_i(wait_load),
		.count_i(wait_cnt),
		.done_o(wait_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// Wait loads are pulses taken on the cycle a command is issued or a refresh burst ends.
	always_comb
	begin
		wait_load = 1'b0;
		wait_cnt = '0;
		case (state_q)
			ST_PRE:
			begin
				wait_load = wait_done;
				wait_cnt = 16'(`SDIS_PRE_CYC);
			end
			ST_MODE:
			begin
				wait_load = wait_done;
				wait_cnt = 16'(`SDIS_MODE_LOAD_WAIT_CYC);
			end
			ST_REF, ST_SR_BREF, ST_SR_AREF:
			begin
				wait_load = wait_done;
				wait_cnt = 16'(`SDIS_ROWCYC_CYC);
			end
			ST_SR_ENTER:
			begin
				wait_load = 1'b1;
				wait_cnt = 16'(`SDIS_ROWACT_CYC);
			end
			ST_SR_CLK:
			begin
				wait_load = wait_done;
				wait_cnt = 16'(`SDIS_XSR_CYC);
			end
			default:
			begin
				wait_load = 1'b0;
				wait_cnt = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequence state and command pins.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_POWER;
			pins_q <= mk_cmd(1'b0, `SDIS_CMD_NOP, 12'h000);
			clk_en_q <= 1'b1;
			ready_q <= 1'b0;
			sr_q <= 1'b0;
			mode_done_q <= 1'b0;
			refs_done_q <= 1'b0;
			ref_cnt_q <= '0;
			pwr_cnt_q <= '0;
		end
		else
		begin
			pins_q <= mk_cmd(pins_q.cke, `SDIS_CMD_NOP, 12'h000);
			case (state_q)
				ST_POWER:
					if (pwr_cnt_q == 16'(STABLE_CYC))
					begin
						state_q <= ST_PRE;
						pins_q <= mk_cmd(1'b1, `SDIS_CMD_NOP, 12'h000);
					end
					else
						pwr_cnt_q <= pwr_cnt_q + 16'h0001;
				ST_PRE:
					if (wait_done)
					begin
						pins_q <= mk_cmd(1'b1, `SDIS_CMD_PRE,
							12'h001 << `SDIS_ALLBANK_BIT);
						ref_cnt_q <= '0;
						state_q <= ref_after_mode_i ? ST_MODE : ST_REF;
					end
				ST_MODE:
					if (wait_done)
					begin
						pins_q <= mk_cmd(1'b1, `SDIS_CMD_MRS, mode_word_i);
						mode_done_q <= 1'b1;
						state_q <= refs_done_q ? ST_IDLE : ST_REF;
					end
				ST_REF:
					if (wait_done)
					begin
						pins_q <= mk_cmd(1'b1, `SDIS_CMD_REF, 12'h000);
						ref_cnt_q <= ref_cnt_q + 13'h0001;
						if (ref_cnt_q == 13'(`SDIS_INIT_REFS - 1))
						begin
							refs_done_q <= 1'b1;
							state_q <= mode_done_q ? ST_IDLE : ST_MODE;
						end
					end
				ST_IDLE:
					if (wait_done)
					begin
						ready_q <= 1'b1;
						pins_q.dqm <= 2'h0;
						if (sr_enter_i && ready_q)
						begin
							ready_q <= 1'b0;
							ref_cnt_q <= '0;
							state_q <= burst_refresh_i ? ST_SR_BREF : ST_SR_ENTER;
						end
					end
				ST_SR_BREF:
					if (wait_done)
					begin
						if (ref_cnt_q == 13'(BURST_REFS))
							state_q <= ST_SR_ENTER;
						else
						begin
							pins_q <= mk_cmd(1'b1, `SDIS_CMD_REF, 12'h000);
							ref_cnt_q <= ref_cnt_q + 13'h0001;
						end
					end
				ST_SR_ENTER:
				begin
					pins_q <= mk_cmd(1'b0, `SDIS_CMD_REF, 12'h000);
					sr_q <= 1'b1;
					state_q <= ST_SR_HOLD;
				end
				ST_SR_HOLD:
				begin
					clk_en_q <= 1'b0;
					if (wait_done && sr_exit_i)
					begin
						clk_en_q <= 1'b1;
						state_q <= ST_SR_CLK;
					end
				end
				ST_SR_CLK:
				begin
					pins_q <= mk_cmd(1'b1, `SDIS_CMD_DESEL, 12'h000);
					state_q <= ST_SR_EXIT;
				end
				ST_SR_EXIT:
				begin
					pins_q <= mk_cmd(1'b1, `SDIS_CMD_DESEL, 12'h000);
					if (wait_done)
					begin
						sr_q <= 1'b0;
						ref_cnt_q <= '0;
						state_q <= burst_refresh_i ? ST_SR_AREF : ST_IDLE;
					end
				end
				ST_SR_AREF:
					if (wait_done)
					begin
						if (ref_cnt_q == 13'(BURST_REFS))
							state_q <= ST_IDLE;
						else
						begin
							pins_q <= mk_cmd(1'b1, `SDIS_CMD_REF, 12'h000);
							ref_cnt_q <= ref_cnt_q + 13'h0001;
						end
					end
				default:
					state_q <= ST_POWER;
			endcase
		end
	end

	assign pins_o = pins_q;
	assign clk_en_o = clk_en_q;
	assign ready_o = ready_q;
	assign in_self_refresh_o = sr_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	AST_PWR_CKE_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_q == ST_POWER |-> !pins_o.cke && pins_o.dqm == 2'h3)
		else $error("Clock enable or masks wrong during power-up.");
	AST_INIT_DQM: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(mode_done_q && refs_done_q) |-> pins_o.dqm == 2'h3)
		else $error("Data masks dropped during initialization.");
	AST_SR_ENTRY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(sr_q) |-> !pins_o.cke && !pins_o.cs_n && !pins_o.ras_n && !pins_o.cas_n
		&& pins_o.we_n)
		else $error("Bad self refresh entry command.");
	AST_SR_CKE_HELD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(sr_q) |=> !pins_o.cke [*2])
		else $error("Clock enable rose right after self refresh entry.");
	AST_SR_DWELL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(sr_q) |=> !pins_o.cke [*4])
		else $error("Self refresh exit before row active time.");
	AST_EXIT_DESEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sr_q && $rose(pins_o.cke) |-> pins_o.cs_n)
		else $error("Chip select low as clock enable returned.");
	AST_EXIT_WAIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sr_q && $rose(pins_o.cke) |-> pins_o.cs_n [*7])
		else $error("Command issued inside self refresh exit time.");
	AST_MODE_GAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		pins_o.cke && {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} == `SDIS_CMD_MRS
		|=> pins_o.cs_n || pins_o.ras_n)
		else $error("Command issued right after mode set.");
	AST_PRE_GAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		pins_o.cke && {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} == `SDIS_CMD_PRE
		|=> ({pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} == `SDIS_CMD_NOP) [*2])
		else $error("Refresh issued inside precharge time.");

endmodule

// >>> hdl/sdis_wait.sv
/*
 * Down counter that reports when a loaded number of cycles has passed.
 * Assumes the owner loads it once per wait and watches done.
 */
`include "sdis_regs.svh"

module sdis_wait (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Load and status.
	input wire logic load_i,
	input wire logic [`SDIS_CNT_W-1:0] count_i,
	output logic done_o
);

	logic [`SDIS_CNT_W-1:0] cnt_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			cnt_q <= '0;
		else if (load_i)
			cnt_q <= count_i;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 16'h0001;
	end

	// Done depends on the count alone, because the owner derives the load from done.
	assign done_o = (cnt_q == '0);

endmodule

// >>> include/sdis_pkg.sv
/*
 * Types for the DRAM power-up and self refresh sequencer.
 * Assumes the constants header is compiled alongside.
 */
package sdis_pkg;

	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] dqm;
		logic [1:0] ba;
		logic [11:0] addr;
	} sdis_pins_t;

	typedef enum logic [1:0] {SDIS_REF_INIT, SDIS_REF_SELF} sdis_ref_kind_t;

endpackage

// >>> include/sdis_regs.svh
/*
 * Timing counts and command encodings for the DRAM
 * power-up and self refresh sequencer.
 * Assumes a 100 MHz controller clock (10 ns period).
 */
`ifndef SDIS_REGS_SVH
`define SDIS_REGS_SVH

// Clock period in picoseconds.
`define SDIS_CLK_PS 10000
// Stable clock time before clock enable rises, in microseconds.
`define SDIS_T_STABLE_US 200
`define SDIS_STABLE_CYC ((`SDIS_T_STABLE_US * 1000000 + `SDIS_CLK_PS - 1) / `SDIS_CLK_PS)
// Precharge time, picoseconds.
`define SDIS_T_PRE_PS 18000
`define SDIS_PRE_CYC ((`SDIS_T_PRE_PS + `SDIS_CLK_PS - 1) / `SDIS_CLK_PS)
// Row cycle time, picoseconds.
`define SDIS_T_ROWCYC_PS 60000
`define SDIS_ROWCYC_CYC ((`SDIS_T_ROWCYC_PS + `SDIS_CLK_PS - 1) / `SDIS_CLK_PS)
// Minimum row active time, picoseconds.
`define SDIS_T_ROWACT_PS 42000
`define SDIS_ROWACT_CYC ((`SDIS_T_ROWACT_PS + `SDIS_CLK_PS - 1) / `SDIS_CLK_PS)
// Input setup time, picoseconds.
`define SDIS_T_INPUT_SETUP_PS 1500
// Self refresh exit time: row cycle plus input setup.
`define SDIS_XSR_CYC ((`SDIS_T_ROWCYC_PS + `SDIS_T_INPUT_SETUP_PS + `SDIS_CLK_PS - 1) / `SDIS_CLK_PS)
// Mode load wait, in clock cycles.
`define SDIS_MODE_LOAD_WAIT_CYC 2
// Number of dummy refreshes at power-up.
`define SDIS_INIT_REFS 2
// Burst refresh count around self refresh.
`define SDIS_BURST_REFS 4096
// Command encodings {cs_n, ras_n, cas_n, we_n}.
`define SDIS_CMD_NOP 4'h7
`define SDIS_CMD_DESEL 4'hF
`define SDIS_CMD_PRE 4'h2
`define SDIS_CMD_REF 4'h1
`define SDIS_CMD_MRS 4'h0
// Precharge-all address bit.
`define SDIS_ALLBANK_BIT 10
`define SDIS_CNT_W 16

`endif
